// ---- src/spmc_core.sv ----
// Function
// - wait mode with clock stop clear runs exactly as in run mode.
// - wait mode with clock stop set halts master clocking, resumes later.
// - stop mode halts master transfer, resumes when run mode returns.
// - slave keeps shifting its byte during wait and stop modes.
// - reserved bits read zero and ignore writes.
// - status writes ignored; reserved locations read all zeros.
// - control one bit 7 raises interrupt on done or fault flag.
// - clearing enable disables module, forces idle, resets status.
// - control one bit 5 raises interrupt on transmit empty flag.
// - bit 4 picks master or slave; any change forces idle.
// - bit 3 sets serial clock idle level.
// - bit 2 samples on odd edges when 0, even edges when 1.
// - bit 0 picks lsb first when 1, msb first when 0.
// - data register always keeps msb in bit 7.
// - master config change on polarity, phase, select, order aborts to idle.
// - select pin role set by master, fault enable and select output.
// - master drives mosi, reads miso; slave the reverse.
// - master drives serial clock; slave shifts on incoming clock.
// - master clock divides bus clock by (pre+1) times 2^(exp+1).
// - control two bit 4 enables fault detection on select pin.
// - control two bit 1 stops serial clock in wait mode.
//
// The plain strobed port is this design's own decision.
`default_nettype none
module spmc_core (
    // clock and reset
    input  wire logic                        ref_clk_in,
    input  wire logic                        arst_n_in,
    // register port
    input  wire logic [spmc_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [7:0]                  wr_data_in,
    input  wire logic                        wr_strobe_in,
    input  wire logic                        rd_strobe_in,
    output logic      [7:0]                  rd_data_out,
    // low power modes
    input  wire logic                        wait_mode_in,
    input  wire logic                        stop_mode_in,
    // interrupt request
    output logic                             irq_out,
    // serial clock pin
    input  wire logic                        sck_in,
    output logic                             sck_out,
    output logic                             sck_oe_out,
    // master out slave in pin
    input  wire logic                        mosi_in,
    output logic                             mosi_out,
    output logic                             mosi_oe_out,
    // master in slave out pin
    input  wire logic                        miso_in,
    output logic                             miso_out,
    output logic                             miso_oe_out,
    // slave select pin, active low
    input  wire logic                        ss_n_in,
    output logic                             ss_n_out,
    output logic                             ss_n_oe_out
);
    import spmc_pkg::*;

    logic [7:0]     ctrl1;
    logic [7:0]     ctrl2;
    logic [7:0]     baud;
    logic [7:0]     tx_buf;
    logic [7:0]     rx_data;
    logic           done_flag;
    logic           fault_flag;
    logic           txe_flag;
    logic           arm_done;
    logic           arm_fault;
    logic           arm_txe;
    spmc_state_type state;
    logic [4:0]     edge_cnt;
    logic [4:0]     edge_num;
    logic           sck_int;
    logic           sck_prev;
    logic           mst_prev;
    logic           done_pend;
    logic           en;
    logic           mst;
    logic           clock_idle_polarity;
    logic           clock_sample_phase;
    logic           fde;
    logic           select_output_enable;
    logic           halt;
    logic           wr_c1;
    logic           wr_c2;
    logic           wr_br;
    logic           wr_dat;
    logic           rd_st;
    logic           rd_dat;
    logic           tick;
    logic           edge_ev;
    logic           last;
    logic           start;
    logic           abort;
    logic           fault_ev;
    logic           cfg_chg;
    logic [7:0]     next_rd;

    spmc_shift_if sh ();

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [2:0] off);
        hit = (a == off);
    endfunction

    function automatic logic is_sample(input logic phase, input logic [4:0] num);
        is_sample = phase ? ~num[0] : num[0];
    endfunction

    // with phase 1 the first edge only launches, the final shift closes the byte
    function automatic logic is_shift(input logic phase, input logic [4:0] num);
        is_shift = phase ? ((num[0] && num != FIRST_EDGE) || num == LAST_EDGE) : ~num[0];
    endfunction

    always_comb begin
        en     = ctrl1[C1_EN];
        mst    = ctrl1[C1_MST];
        clock_idle_polarity   = ctrl1[C1_CLOCK_IDLE_POLARITY];
        clock_sample_phase   = ctrl1[C1_CLOCK_SAMPLE_PHASE];
        select_output_enable   = ctrl1[C1_SELECT_OUTPUT_ENABLE];
        fde    = ctrl2[C2_FDE];
        wr_c1  = wr_strobe_in && hit(addr_in, OFF_CTRL1);
        wr_c2  = wr_strobe_in && hit(addr_in, OFF_CTRL2);
        wr_br  = wr_strobe_in && hit(addr_in, OFF_BAUD);
        wr_dat = wr_strobe_in && hit(addr_in, OFF_DATA);
        rd_st  = rd_strobe_in && hit(addr_in, OFF_STAT);
        rd_dat = rd_strobe_in && hit(addr_in, OFF_DATA);
    end

    // a slave never halts so it stays locked to the far master
    always_comb begin
        halt = stop_mode_in || (wait_mode_in && ctrl2[C2_WCS]);
    end

    always_comb begin
        fault_ev = en && mst && fde && !select_output_enable && !ss_n_in;
        cfg_chg  = mst && ((wr_c1 && ((wr_data_in ^ ctrl1) & CFG_ABORT_MASK) != 8'h00)
                   || (wr_c2 && wr_data_in[C2_FDE] != fde)
                   || (wr_br && ((wr_data_in ^ baud) & BAUD_MASK) != 8'h00));
        abort    = !en || (mst != mst_prev) || cfg_chg || fault_ev || (!mst && ss_n_in);
        start    = (state == SPMC_IDLE) && en && !abort
                   && (mst ? (!txe_flag && !halt) : !ss_n_in);
        edge_num = edge_cnt + FIRST_EDGE;
        edge_ev  = (state == SPMC_RUN) && !abort
                   && (mst ? tick : (sck_in != sck_prev));
        last     = edge_ev && (edge_num == LAST_EDGE);
    end

    always_comb begin
        sh.load      = start;
        sh.load_data = tx_buf;
        sh.sample    = edge_ev && is_sample(clock_sample_phase, edge_num);
        sh.shift     = edge_ev && is_shift(clock_sample_phase, edge_num);
        sh.in_bit    = mst ? miso_in : mosi_in;
        sh.lsb_first = ctrl1[C1_LSBF];
    end

    spmc_shifter u_shifter (
        .ref_clk_in (ref_clk_in),
        .arst_n_in  (arst_n_in),
        .sh         (sh.shifter)
    );

    spmc_baud_gen #(
        .CNT_W (DIV_CNT_W)
    ) u_baud (
        .ref_clk_in   (ref_clk_in),
        .arst_n_in    (arst_n_in),
        .run_in       ((state == SPMC_RUN) && mst && !halt),
        .clear_in     (state != SPMC_RUN),
        .preselect_in (baud[BR_PRE_LO +: 3]),
        .exponent_in  (baud[BR_EXP_LO +: 3]),
        .tick_out     (tick)
    );

    // a fault drops master select after any same cycle write
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ctrl1 <= CTRL1_RST;
        end else begin
            if (wr_c1) begin
                ctrl1 <= wr_data_in;
            end
            if (fault_ev) begin
                ctrl1[C1_MST] <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ctrl2 <= CTRL2_RST;
            baud  <= BAUD_RST;
        end else begin
            if (wr_c2) begin
                ctrl2 <= wr_data_in & C2_MASK;
            end
            if (wr_br) begin
                baud <= wr_data_in & BAUD_MASK;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state    <= SPMC_IDLE;
            edge_cnt <= 5'h00;
        end else if (abort) begin
            state    <= SPMC_IDLE;
            edge_cnt <= 5'h00;
        end else if (start) begin
            state    <= SPMC_RUN;
            edge_cnt <= 5'h00;
        end else if (last) begin
            state    <= SPMC_IDLE;
            edge_cnt <= 5'h00;
        end else if (edge_ev) begin
            edge_cnt <= edge_num;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sck_int <= 1'b0;
        end else if (state != SPMC_RUN || abort) begin
            sck_int <= clock_idle_polarity;
        end else if (mst && edge_ev) begin
            sck_int <= ~sck_int;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sck_prev  <= 1'b0;
            mst_prev  <= 1'b0;
            done_pend <= 1'b0;
            rx_data   <= 8'h00;
        end else begin
            sck_prev  <= sck_in;
            mst_prev  <= mst;
            done_pend <= last && en;
            if (done_pend) begin
                rx_data <= sh.data;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            tx_buf <= 8'h00;
        end else if (wr_dat && arm_txe && txe_flag) begin
            tx_buf <= wr_data_in;
        end
    end

    // set beats clear in every flag below
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            txe_flag <= 1'b1;
            arm_txe  <= 1'b0;
        end else if (!en) begin
            txe_flag <= 1'b1;
            arm_txe  <= 1'b0;
        end else begin
            if (start && !txe_flag) begin
                txe_flag <= 1'b1;
            end else if (wr_dat && arm_txe) begin
                txe_flag <= 1'b0;
            end
            if (rd_st && txe_flag) begin
                arm_txe <= 1'b1;
            end else if (wr_dat) begin
                arm_txe <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            done_flag <= 1'b0;
            arm_done  <= 1'b0;
        end else if (!en) begin
            done_flag <= 1'b0;
            arm_done  <= 1'b0;
        end else begin
            if (done_pend) begin
                done_flag <= 1'b1;
            end else if (rd_dat && arm_done) begin
                done_flag <= 1'b0;
            end
            if (rd_st && done_flag) begin
                arm_done <= 1'b1;
            end else if (rd_dat) begin
                arm_done <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            fault_flag <= 1'b0;
            arm_fault  <= 1'b0;
        end else if (!en) begin
            fault_flag <= 1'b0;
            arm_fault  <= 1'b0;
        end else begin
            if (fault_ev) begin
                fault_flag <= 1'b1;
            end else if (wr_c1 && arm_fault) begin
                fault_flag <= 1'b0;
            end
            if (rd_st && fault_flag) begin
                arm_fault <= 1'b1;
            end else if (wr_c1) begin
                arm_fault <= 1'b0;
            end
        end
    end

    always_comb begin
        next_rd = 8'h00;
        case (addr_in)
            OFF_CTRL1: next_rd = ctrl1;
            OFF_CTRL2: next_rd = ctrl2;
            OFF_BAUD:  next_rd = baud;
            OFF_STAT:  next_rd = {done_flag, 1'b0, txe_flag, fault_flag, 4'h0};
            OFF_DATA:  next_rd = rx_data;
            default:   next_rd = 8'h00;
        endcase
    end

    // read data stand for one cycle only, zero otherwise
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rd_data_out <= 8'h00;
        end else begin
            rd_data_out <= rd_strobe_in ? next_rd : 8'h00;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= en && ((ctrl1[C1_XIE] && (done_flag || fault_flag))
                       || (ctrl1[C1_TIE] && txe_flag));
        end
    end

    // pins are registered, so every pin lags the internal sequencer by one cycle
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sck_out     <= 1'b0;
            sck_oe_out  <= 1'b0;
            mosi_out    <= 1'b0;
            mosi_oe_out <= 1'b0;
            miso_out    <= 1'b0;
            miso_oe_out <= 1'b0;
            ss_n_out    <= 1'b1;
            ss_n_oe_out <= 1'b0;
        end else begin
            sck_out     <= sck_int;
            sck_oe_out  <= en && mst;
            mosi_out    <= sh.out_bit;
            mosi_oe_out <= en && mst;
            miso_out    <= sh.out_bit;
            miso_oe_out <= en && !mst && !ss_n_in;
            ss_n_out    <= state != SPMC_RUN;
            ss_n_oe_out <= en && mst && fde && select_output_enable;
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!arst_n_in);

    sequence s_master_busy;
        en && mst && state == SPMC_RUN && !abort;
    endsequence
    sequence s_slave_edge;
        en && !mst && state == SPMC_RUN && !abort && sck_in != sck_prev;
    endsequence
    sequence s_idle_master;
        en && mst && state == SPMC_IDLE && $stable(clock_idle_polarity);
    endsequence

    a_run_in_wait: assert property (s_master_busy ##0 (tick && !halt)
                                    |=> edge_cnt == $past(last ? 5'h00 : edge_num))
        else $error("master did not advance with clocks running");
    a_halt_freeze: assert property (s_master_busy ##0 halt |=> edge_cnt == $past(edge_cnt))
        else $error("halted master kept clocking");
    a_slave_keeps: assert property (s_slave_edge ##0 halt |=> edge_cnt == $past(last ? 5'h00 : edge_num))
        else $error("slave stopped shifting in low power mode");
    a_rsvd_zero: assert property (rd_strobe_in && (addr_in == OFF_RSVD_A || addr_in == OFF_RSVD_C)
                                  |=> rd_data_out == 8'h00)
        else $error("reserved location read nonzero");
    a_irq_done: assert property (en && ctrl1[C1_XIE] && (done_flag || fault_flag) |=> irq_out)
        else $error("done or fault did not raise interrupt");
    a_disable_idle: assert property (!en |=> state == SPMC_IDLE && !done_flag && !fault_flag && txe_flag)
        else $error("disable did not idle and reset status");
    a_irq_txe: assert property (en && ctrl1[C1_TIE] && txe_flag |=> irq_out)
        else $error("transmit empty did not raise interrupt");
    a_role_idle: assert property (mst != mst_prev |=> state == SPMC_IDLE && edge_cnt == 5'h00)
        else $error("role change did not idle");
    a_sck_idle: assert property (s_idle_master ##1 s_idle_master |=> sck_out == $past(clock_idle_polarity))
        else $error("serial clock not at idle level");
    a_cfg_abort: assert property (cfg_chg |=> state == SPMC_IDLE && edge_cnt == 5'h00)
        else $error("config change did not abort transfer");
    a_fault_trip: assert property (fault_ev |=> fault_flag && !ctrl1[C1_MST] && state == SPMC_IDLE)
        else $error("mode fault not taken");
    a_byte_done: assert property (last ##1 en |=> done_flag && rx_data == $past(sh.data))
        else $error("completed byte not posted");
    a_ss_framed: assert property (s_master_busy ##0 (fde && select_output_enable) |=> !ss_n_out && ss_n_oe_out)
        else $error("select not low during master byte");
endmodule
`default_nettype wire

// ---- inc/spmc_pkg.sv ----
`default_nettype none
package spmc_pkg;
    // register port
    localparam int         ADDR_W     = 3;
    localparam logic [2:0] OFF_CTRL1  = 3'h0;
    localparam logic [2:0] OFF_CTRL2  = 3'h1;
    localparam logic [2:0] OFF_BAUD   = 3'h2;
    localparam logic [2:0] OFF_STAT   = 3'h3;
    localparam logic [2:0] OFF_RSVD_A = 3'h4;
    localparam logic [2:0] OFF_DATA   = 3'h5;
    localparam logic [2:0] OFF_RSVD_B = 3'h6;
    localparam logic [2:0] OFF_RSVD_C = 3'h7;
    // serial_control_one fields
    localparam int C1_XIE  = 7;
    localparam int C1_EN   = 6;
    localparam int C1_TIE  = 5;
    localparam int C1_MST  = 4;
    localparam int C1_CLOCK_IDLE_POLARITY = 3;
    localparam int C1_CLOCK_SAMPLE_PHASE = 2;
    localparam int C1_SELECT_OUTPUT_ENABLE = 1;
    localparam int C1_LSBF = 0;
    // serial_control_two fields
    localparam int C2_FDE = 4;
    localparam int C2_WCS = 1;
    // serial_clock_divider fields
    localparam int BR_PRE_LO = 4;
    localparam int BR_EXP_LO = 0;
    // serial_status fields
    localparam int ST_DONE  = 7;
    localparam int ST_TXE   = 5;
    localparam int ST_FAULT = 4;
    // writable masks, abort mask and reset values
    localparam logic [7:0] C2_MASK        = 8'h12;
    localparam logic [7:0] BAUD_MASK      = 8'h77;
    localparam logic [7:0] CFG_ABORT_MASK = 8'h0f;
    localparam logic [7:0] CTRL1_RST      = 8'h00;
    localparam logic [7:0] CTRL2_RST      = 8'h00;
    localparam logic [7:0] BAUD_RST       = 8'h00;
    // sequencing
    localparam logic [4:0] FIRST_EDGE = 5'h01;
    localparam logic [4:0] LAST_EDGE  = 5'h10;
    localparam int         DIV_CNT_W  = 11;
    typedef enum logic [0:0] {SPMC_IDLE, SPMC_RUN} spmc_state_type;
endpackage
`default_nettype wire

// ---- inc/spmc_shift_if.sv ----
`default_nettype none
interface spmc_shift_if;
    logic       load;
    logic [7:0] load_data;
    logic       sample;
    logic       shift;
    logic       in_bit;
    logic       lsb_first;
    logic       out_bit;
    logic [7:0] data;
    modport ctrl (output load, load_data, sample, shift, in_bit, lsb_first,
                  input  out_bit, data);
    modport shifter (input  load, load_data, sample, shift, in_bit, lsb_first,
                     output out_bit, data);
endinterface
`default_nettype wire

// ---- src/spmc_baud_gen.sv ----
`default_nettype none
module spmc_baud_gen #(
    parameter int CNT_W = spmc_pkg::DIV_CNT_W
) (
    // clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       arst_n_in,
    // control
    input  wire logic       run_in,
    input  wire logic       clear_in,
    input  wire logic [2:0] preselect_in,
    input  wire logic [2:0] exponent_in,
    // half period strobe
    output logic            tick_out
);
    import spmc_pkg::*;
    logic [CNT_W-1:0] half;
    logic [CNT_W-1:0] cnt;
    always_comb begin
        half     = CNT_W'({1'b0, preselect_in} + 4'h1) << exponent_in;
        tick_out = run_in && (cnt == half - CNT_W'(1));
    end
    // a stopped run keeps the count so a halted byte resumes mid bit
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt <= '0;
        end else if (clear_in) begin
            cnt <= '0;
        end else if (run_in) begin
            cnt <= tick_out ? '0 : cnt + CNT_W'(1);
        end
    end
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!arst_n_in);
    a_tick_gap_min: assert property (tick_out && half > CNT_W'(1) && !clear_in |=> !tick_out)
        else $error("baud tick repeated inside a half period");
endmodule
`default_nettype wire

// ---- src/spmc_shifter.sv ----
`default_nettype none
module spmc_shifter (
    // clock and reset
    input  wire logic     ref_clk_in,
    input  wire logic     arst_n_in,
    // control side
    spmc_shift_if.shifter sh
);
    import spmc_pkg::*;
    logic [7:0] sreg;
    logic       held;
    logic       next_bit;
    always_comb begin
        next_bit = sh.sample ? sh.in_bit : held;
    end
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            held <= 1'b0;
        end else if (sh.sample) begin
            held <= sh.in_bit;
        end
    end
    // bit 7 is the msb in both orders, only the shift direction changes
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sreg <= 8'h00;
        end else if (sh.load) begin
            sreg <= sh.load_data;
        end else if (sh.shift) begin
            sreg <= sh.lsb_first ? {next_bit, sreg[7:1]} : {sreg[6:0], next_bit};
        end
    end
    assign sh.out_bit = sh.lsb_first ? sreg[0] : sreg[7];
    assign sh.data    = sreg;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!arst_n_in);
    a_msb_first_in: assert property (sh.shift && !sh.load && !sh.lsb_first |=> sreg[0] == $past(next_bit))
        else $error("msb first shift lost its input bit");
    a_lsb_first_in: assert property (sh.shift && !sh.load && sh.lsb_first |=> sreg[7] == $past(next_bit))
        else $error("lsb first shift did not fill bit 7");
endmodule
`default_nettype wire

// ---- test/spmc_far_node.sv ----
`default_nettype none
module spmc_far_node (
    // serial pins
    input  wire logic       sck_in,
    input  wire logic       ss_n_in,
    input  wire logic       mosi_in,
    output logic            miso_out,
    // byte to send, byte seen
    input  wire logic [7:0] tx_in,
    output logic      [7:0] rx_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sh = 8'h00;
    logic       last = 1'b0;
    // idle low clock, odd edge sampling only, like the device setup used
    always @(negedge ss_n_in) sh = tx_in;
    always @(posedge sck_in) if (!ss_n_in) rx_out = {rx_out[6:0], mosi_in};
    always @(negedge sck_in) if (!ss_n_in) sh = {sh[6:0], 1'b0};
    always @(posedge ss_n_in) last = sh[7];
    // released line shows the inverse so stale bits never look valid
    assign miso_out = ss_n_in ? ~last : sh[7];
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import spmc_pkg::*;
    logic       ref_clk_in = 0, arst_n_in = 0, wr = 0, rd = 0, wm = 0, sm = 0;
    logic [2:0] ad = 0;
    logic [7:0] wd = 0, rdo, ftx = 0, frx, d, e;
    logic       irq, sck, sck_oe, mo, mo_oe, mi, mi_oe, sso, sso_oe, fmiso, b;
    logic       ssck = 1, smosi = 0, sss_n = 1;
    int         n_fail = 0, cmp_count = 0, i;
    logic [2:0] ofs [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
    logic [7:0] ev [6] = '{8'h12, 8'h77, 8'h20, 8'h00, 8'h00, 8'h00};
    wire logic  ss_line = sso_oe ? sso : 1'b1;
    spmc_core DUT (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .addr_in(ad), .wr_data_in(wd),
        .wr_strobe_in(wr), .rd_strobe_in(rd), .rd_data_out(rdo), .wait_mode_in(wm), .stop_mode_in(sm),
        .irq_out(irq), .sck_in(ssck), .sck_out(sck), .sck_oe_out(sck_oe), .mosi_in(smosi), .mosi_out(mo),
        .mosi_oe_out(mo_oe), .miso_in(fmiso), .miso_out(mi), .miso_oe_out(mi_oe), .ss_n_in(sss_n),
        .ss_n_out(sso), .ss_n_oe_out(sso_oe));
    spmc_far_node far (.sck_in(sck), .ss_n_in(ss_line), .mosi_in(mo), .miso_out(fmiso), .tx_in(ftx),
        .rx_out(frx));
    initial begin
        forever #2.5 ref_clk_in = ~ref_clk_in;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [2:0] a, input logic [7:0] v);
        @(posedge ref_clk_in) begin wr <= 1; ad <= a; wd <= v; end
        @(posedge ref_clk_in) wr <= 0;
    endtask
    task automatic rreg(input logic [2:0] a, output logic [7:0] v);
        @(posedge ref_clk_in) begin rd <= 1; ad <= a; end
        @(posedge ref_clk_in) rd <= 0;
        #1 v = rdo;
    endtask
    // halt 1 uses stop mode, 2 uses wait mode; both must freeze the master clock
    task automatic xfer(input logic [7:0] t, input logic [7:0] f, input int halt);
        ftx = f;
        rreg(OFF_STAT, d);
        wreg(OFF_DATA, t);
        if (halt != 0) begin
            repeat (20) @(posedge ref_clk_in);
            if (halt == 1) sm <= 1; else wm <= 1;
            repeat (2) @(posedge ref_clk_in);
            b = sck;
            repeat (60) @(posedge ref_clk_in);
            chk({6'h0, sck, ss_line}, {6'h0, b, 1'b0});
            sm <= 0;
            wm <= 0;
        end
        d = 0;
        for (i = 0; i < 200 && d[7] !== 1'b1; i++) rreg(OFF_STAT, d);
        chk(d & 8'h80, 8'h80);
        chk({7'h0, irq}, 8'h01);
    endtask
    task automatic complete_run;
        $display("mismatches %0d comparisons %0d", n_fail, cmp_count);
        if (n_fail == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #100us;
        n_fail++;
        complete_run();
    end
    initial begin
        repeat (3) @(posedge ref_clk_in);
        arst_n_in <= 1;
        for (int k = 0; k < 8; k++) begin
            rreg(k[2:0], d);
            chk(d, (k == 3) ? 8'h20 : 8'h00);
        end
        for (int k = 0; k < 6; k++) begin
            wreg(ofs[k], 8'hff);
            rreg(ofs[k], d);
            chk(d, ev[k]);
        end
        // divisor 8 gives four bus cycles per edge, room for the far node
        wreg(OFF_BAUD, 8'h02);
        wreg(OFF_CTRL2, 8'h10);
        wreg(OFF_CTRL1, 8'hd2);
        repeat (2) @(posedge ref_clk_in);
        chk({3'h0, sck, sso_oe, sck_oe, mo_oe, mi_oe}, 8'h0e);
        xfer(8'ha5, 8'h1e, 0);
        chk(frx, 8'ha5);
        rreg(OFF_DATA, d);
        chk(d, 8'h1e);
        wreg(OFF_CTRL1, 8'hd3);
        xfer(8'h01, 8'h1e, 0);
        chk(frx, 8'h80);
        rreg(OFF_DATA, d);
        chk(d, 8'h78);
        wreg(OFF_CTRL1, 8'hd2);
        xfer(8'h3c, 8'hc3, 1);
        chk(frx, 8'h3c);
        rreg(OFF_DATA, d);
        chk(d, 8'hc3);
        wreg(OFF_CTRL2, 8'h12);
        xfer(8'h96, 8'h5a, 2);
        chk(frx, 8'h96);
        // select pulled low while master without select output trips the fault
        wreg(OFF_CTRL1, 8'hdc);
        sss_n <= 0;
        rreg(OFF_STAT, d);
        chk(d, 8'hb0);
        rreg(OFF_CTRL1, d);
        chk(d, 8'hcc);
        // now a slave: idle high clock, even edge sampling, stop mode mid byte
        e = 8'h69;
        for (int k = 7; k >= 0; k--) begin
            @(posedge ref_clk_in) begin ssck <= 0; smosi <= e[k]; end
            repeat (3) @(posedge ref_clk_in);
            d = {d[6:0], mi};
            ssck <= 1;
            if (k == 4) sm <= 1;
            repeat (2) @(posedge ref_clk_in);
        end
        chk({6'h0, mi_oe, sck_oe}, 8'h02);
        chk(d, 8'h96);
        sss_n <= 1;
        sm <= 0;
        rreg(OFF_DATA, d);
        chk(d, 8'h69);
        wreg(OFF_CTRL1, 8'h00);
        rreg(OFF_STAT, d);
        chk(d, 8'h20);
        chk({7'h0, irq}, 8'h00);
        complete_run();
    end
endmodule
`default_nettype wire
